// ---- bench/cic_core_asserts.sv ----
// concurrent checks on the interrupt control ports
`timescale 1ns/1ps
module cic_core_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // sequencer side in
  input wire logic first_clock_phase,
  input wire logic return_from_irq_instr,
  input wire logic [7:0] ctx_w,
  input wire logic [7:0] ctx_status,
  input wire logic [5:0] ctx_bsr,
  input wire logic [15:0] ctx_fsr0,
  input wire logic [15:0] ctx_fsr1,
  input wire logic [6:0] ctx_pch,
  // sequencer side out
  input wire logic vector_take,
  input wire logic [15:0] vector_addr,
  input wire logic restore_take,
  input wire logic wake,
  input wire logic global_irq_enable,
  input wire logic [7:0] shd_w,
  input wire logic [7:0] shd_status,
  input wire logic [5:0] shd_bsr,
  input wire logic [15:0] shd_fsr0,
  input wire logic [15:0] shd_fsr1,
  input wire logic [6:0] shd_pch
);
  // one domain; reset quiets every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rst_quiet_a: assert property ($rose(nrst) |-> !global_irq_enable)
    else $error("global enable set after reset");
  vec_cause_a: assert property (
    vector_take |-> $past(first_clock_phase) && $past(global_irq_enable))
    else $error("vector outside sampling phase");
  vec_entry_a: assert property (
    vector_take |-> !global_irq_enable && vector_addr == 16'h0004
    ##1 !vector_take) else $error("bad vector entry");
  shadow_cap_a: assert property (
    vector_take |-> shd_w == $past(ctx_w)
    && shd_status == ($past(ctx_status) & 8'he7))
    else $error("shadow context wrong");
  shadow_rest_a: assert property (
    vector_take |-> shd_bsr == $past(ctx_bsr)
    && shd_fsr0 == $past(ctx_fsr0) && shd_fsr1 == $past(ctx_fsr1)
    && shd_pch == $past(ctx_pch))
    else $error("shadow bank, file or latch wrong");
  // w, status, bsr and pch shadows move only on an entry, so they hold until the next one
  shadow_hold_a: assert property (
    !vector_take |-> $stable(shd_w) && $stable(shd_status)
    && $stable(shd_bsr) && $stable(shd_pch))
    else $error("shadow changed without entry");
  gie_hold_a: assert property (
    !global_irq_enable |=> !vector_take) else $error("vector while disabled");
  restore_set_a: assert property (
    return_from_irq_instr |=> restore_take && global_irq_enable)
    else $error("return did not restore");
  restore_cause_a: assert property (
    restore_take |-> $past(return_from_irq_instr))
    else $error("restore without return");
  wake_first_a: assert property (
    wake |-> !vector_take [*5]) else $error("vector too soon after wake");
endmodule : cic_core_asserts

bind cic_core cic_core_asserts i_cic_core_asserts (.ref_clk, .nrst,
  .first_clock_phase, .return_from_irq_instr, .ctx_w, .ctx_status,
  .ctx_bsr, .ctx_fsr0, .ctx_fsr1, .ctx_pch,
  .vector_take, .vector_addr, .restore_take, .wake, .global_irq_enable,
  .shd_w, .shd_status, .shd_bsr, .shd_fsr0, .shd_fsr1, .shd_pch);

// ---- bench/cic_core_tb.sv ----
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
module cic_core_tb;
  logic ref_clk = 1'h0, nrst = 1'h0, timer_evt = 1'h0, ioc_evt = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_pin = 1'h0;
  logic sleep_active = 1'h0, return_from_irq_instr = 1'h0;
  logic [7:0] peri_evt = 8'h00, peri_clockless = 8'h01;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, vector_take, restore_take, wake, irq;
  logic global_irq_enable, first_clock_phase;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] vector_addr, ctx_fsr0, ctx_fsr1;
  logic [7:0] ctx_w, ctx_status, shd_w, shd_status;
  logic [6:0] ctx_pch;
  logic [5:0] ctx_bsr;
  int bad_count = 0, num_checks = 0, nvec = 0, nwake = 0, cyc = 0;
  cic_core i_cic_core (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_evt, .ioc_evt,
    .peri_evt, .peri_clockless, .ext_pin, .first_clock_phase,
    .sleep_active, .return_from_irq_instr, .ctx_w, .ctx_status, .ctx_bsr,
    .ctx_fsr0, .ctx_fsr1, .ctx_pch, .vector_take, .vector_addr,
    .restore_take, .wake, .global_irq_enable, .shd_w, .shd_status,
    .shd_bsr(), .shd_fsr0(), .shd_fsr1(), .shd_pch(), .irq);
  cic_seq i_cic_seq (.ref_clk, .nrst, .first_clock_phase, .ctx_w,
    .ctx_status, .ctx_bsr, .ctx_fsr0, .ctx_fsr1, .ctx_pch);
  always #12.5 ref_clk = ~ref_clk;
  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    nvec <= nvec + int'(vector_take === 1'h1);
    nwake <= nwake + int'(wake === 1'h1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("ERROR %0t: %s", $time, m);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp === (a > 8'h1c ? 2'b10 : 2'b00), "bad write response");
    s_axi_bready <= 1'h0;
    idle(1);
  endtask : wr
  // read compares response code and data together
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk({s_axi_rresp, s_axi_rdata} === e, "read mismatch");
    s_axi_rready <= 1'h0;
    idle(1);
  endtask : rd
  task automatic ret;
    return_from_irq_instr <= 1'h1;
    idle(1);
    return_from_irq_instr <= 1'h0;
    idle(12);
  endtask : ret
  task automatic t_core;
    wr(8'h04, 8'h20);
    wr(8'h00, 8'h81);
    timer_evt <= 1'h1;
    idle(1);
    timer_evt <= 1'h0;
    idle(12);
    chk(nvec == 1, "core source did not vector");
    ioc_evt <= 1'h1;
    idle(1);
    ioc_evt <= 1'h0;
    idle(12);
    chk(nvec == 1, "vector during service");
    rd(8'h08, 34'h000000030);
    wr(8'h08, 8'h00);
    ret();
    chk(global_irq_enable === 1'h1 && nvec == 1, "return failed");
  endtask : t_core
  // pending peripheral flag waits for the group enable
  task automatic t_peri;
    wr(8'h0c, 8'h01);
    peri_evt <= 8'h01;
    idle(1);
    peri_evt <= 8'h00;
    idle(12);
    chk(nvec == 1, "vector without group enable");
    rd(8'h10, 34'h000000001);
    wr(8'h00, 8'hc1);
    idle(12);
    chk(nvec == 2, "pending flag not serviced");
    wr(8'h10, 8'h00);
    ret();
  endtask : t_peri
  task automatic t_ext;
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h80);
    ext_pin <= 1'h1;
    idle(12);
    chk(nvec == 2, "vector on unselected edge");
    ext_pin <= 1'h0;
    idle(12);
    chk(nvec == 3, "no vector on selected edge");
    rd(8'h08, 34'h000000001);
    wr(8'h08, 8'h00);
    ret();
  endtask : t_ext
  // sleep drops as soon as wake shows, as a real core would
  task automatic t_sleep;
    wr(8'h0c, 8'h03);
    wr(8'h00, 8'h41);
    sleep_active <= 1'h1;
    peri_evt <= 8'h02;
    idle(1);
    peri_evt <= 8'h00;
    idle(8);
    chk(nwake == 0, "clock-bound source woke from sleep");
    peri_evt <= 8'h01;
    idle(1);
    peri_evt <= 8'h00;
    repeat (12) if (wake !== 1'h1) idle(1);
    sleep_active <= 1'h0;
    idle(12);
    chk(nwake == 1, "clockless source did not wake once");
    chk(nvec == 3, "vector on wake with global off");
  endtask : t_sleep
  // wake with global enable on vectors, one instruction later
  task automatic t_wake;
    wr(8'h10, 8'h00);
    wr(8'h00, 8'hc1);
    sleep_active <= 1'h1;
    idle(4);
    peri_evt <= 8'h01;
    idle(1);
    peri_evt <= 8'h00;
    repeat (12) if (wake !== 1'h1) idle(1);
    sleep_active <= 1'h0;
    idle(12);
    chk(nwake == 2, "clockless source did not wake again");
    chk(nvec == 4, "no vector after wake with global on");
    wr(8'h10, 8'h00);
    ret();
  endtask : t_wake
  task automatic t_irq;
    chk(irq === 1'h0, "irq raised while masked");
    rd(8'h18, 34'h000000007);
    wr(8'h1c, 8'h07);
    rd(8'h1c, 34'h000000007);
    chk(irq === 1'h1, "unmasked status not raised");
    wr(8'h18, 8'h07);
    rd(8'h18, 34'h000000000);
    chk(irq === 1'h0, "status not cleared");
  endtask : t_irq
  // a mid-run reset drops enables that software had set
  task automatic t_reset;
    wr(8'h00, 8'h81);
    chk(global_irq_enable === 1'h1, "global enable not set");
    nrst <= 1'h0;
    idle(2);
    nrst <= 1'h1;
    chk(global_irq_enable === 1'h0, "global enable kept over reset");
    rd(8'h00, 34'h000000001);
    rd(8'h0c, 34'h000000000);
    rd(8'h1c, 34'h000000000);
  endtask : t_reset
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    idle(20);
    nrst <= 1'h1;
    rd(8'h00, 34'h000000001);
    rd(8'h04, 34'h000000000);
    rd(8'h40, 34'h200000000);
    wr(8'h40, 8'h55);
    t_core();
    t_peri();
    t_ext();
    t_sleep();
    t_wake();
    t_irq();
    t_reset();
    results();
  end
endmodule : cic_core_tb

// ---- bench/cic_seq.sv ----
// sequencer model: phase strobe and live context
`timescale 1ns/1ps
module cic_seq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // phase and context to the block
  output logic first_clock_phase,
  output logic [7:0] ctx_w,
  output logic [7:0] ctx_status,
  output logic [5:0] ctx_bsr,
  output logic [15:0] ctx_fsr0,
  output logic [15:0] ctx_fsr1,
  output logic [6:0] ctx_pch
);
  logic [7:0] cnt_reg;
  // four clocks per instruction; context moves every clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_reg <= 8'h00;
    else cnt_reg <= cnt_reg + 8'h01;
  end
  assign first_clock_phase = cnt_reg[1:0] == 2'h0;
  assign ctx_w = cnt_reg;
  assign ctx_status = ~cnt_reg; // inverted count sets bits 4,3 in some cycles, so the shadow must drop them
  assign ctx_bsr = cnt_reg[5:0];
  assign ctx_fsr0 = {cnt_reg, cnt_reg};
  assign ctx_fsr1 = {8'h00, cnt_reg};
  assign ctx_pch = cnt_reg[6:0];
endmodule : cic_seq

// ---- verilog/cic_core.sv ----
// interrupt gating, vectoring, context shadow and wake logic
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "cic_map.svh"
// Operation
// R01: reset clears all enables, no vectoring
// R02: vector needs global, own, group enable
// R03: core-level sources skip group enable
// R04: flags set regardless of enables
// R05: entry flushes, clears global, pushes, vectors
// R06: entry copies context into shadow registers
// R07: global clear: events only set flags
// R08: return pops, restores, sets global
// R09: pending flag serviced when global re-set
// R10: firmware clears flags before return
// R11: requests sampled in first clock phase
// R12: only clockless sources wake from sleep
// R13: wake vectors if global set, else resumes
// R14: instruction after sleep runs before vectoring
// R15: external pin edge request, gated by enable
// R16: edge select: one rising, zero falling
// R17: valid edge sets external flag, may vector
// R18: pin edge synchronised before setting flag
module cic_core #(
  parameter int NPERI = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event sources
  input wire logic timer_evt,
  input wire logic ioc_evt,
  input wire logic [NPERI-1:0] peri_evt,
  input wire logic [NPERI-1:0] peri_clockless,
  input wire logic ext_pin,
  // sequencer side
  input wire logic first_clock_phase,
  input wire logic sleep_active,
  input wire logic return_from_irq_instr,
  input wire logic [7:0] ctx_w,
  input wire logic [7:0] ctx_status,
  input wire logic [5:0] ctx_bsr,
  input wire logic [15:0] ctx_fsr0,
  input wire logic [15:0] ctx_fsr1,
  input wire logic [6:0] ctx_pch,
  output logic vector_take,
  output logic [15:0] vector_addr,
  output logic restore_take,
  output logic wake,
  output logic global_irq_enable,
  output logic [7:0] shd_w,
  output logic [7:0] shd_status,
  output logic [5:0] shd_bsr,
  output logic [15:0] shd_fsr0,
  output logic [15:0] shd_fsr1,
  output logic [6:0] shd_pch,
  // interrupt to system
  output logic irq
);
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  localparam logic [7:0] ST_SAVE =
    ~((8'h01 << `CIC_ST_TO) | (8'h01 << `CIC_ST_PD));

  // register state
  logic [7:0] irq_control_reg, irq_control_next;
  logic [7:0] core_source_enable_reg, core_source_enable_next;
  logic [7:0] core_source_flag_reg, core_source_flag_next;
  logic [NPERI-1:0] peri_en_reg, peri_en_next;
  logic [NPERI-1:0] peripheral_flag_reg_first, peri_flag_next;
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  cic_pkg::cic_state_t state_reg, state_next;
  // bus holding state
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // pin synchroniser and edge detect
  logic pin_s1_reg, pin_s2_reg, pin_s3_reg;

  // address decode and write strobes
  wire wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_lane = wr_go & wstrb_reg[0];
  wire [7:0] wd = wdata_reg[7:0];
  wire wr_ctrl = wr_lane & (awaddr_reg == `CIC_OFF_CTRL);
  wire wr_cen = wr_lane & (awaddr_reg == `CIC_OFF_CORE_EN);
  wire wr_cflag = wr_lane & (awaddr_reg == `CIC_OFF_CORE_FLAG);
  wire wr_pen = wr_lane & (awaddr_reg == `CIC_OFF_PERI_EN);
  wire wr_pflag = wr_lane & (awaddr_reg == `CIC_OFF_PERI_FLAG);
  wire wr_stat = wr_lane & (awaddr_reg == `CIC_OFF_IRQ_STAT);
  wire wr_mask = wr_lane & (awaddr_reg == `CIC_OFF_IRQ_MASK);
  wire wr_known = (awaddr_reg == `CIC_OFF_CTRL) |
    (awaddr_reg == `CIC_OFF_CORE_EN) | (awaddr_reg == `CIC_OFF_CORE_FLAG) |
    (awaddr_reg == `CIC_OFF_PERI_EN) | (awaddr_reg == `CIC_OFF_PERI_FLAG) |
    (awaddr_reg == `CIC_OFF_SHADOW_ST) |
    (awaddr_reg == `CIC_OFF_IRQ_STAT) | (awaddr_reg == `CIC_OFF_IRQ_MASK);

  // selected pin edge, taken from synchronised stages only
  wire pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire pin_fall = ~pin_s2_reg & pin_s3_reg;
  wire ext_edge = irq_control_reg[`CIC_CTRL_EDGE] ? pin_rise : pin_fall; // R16

  // hardware set terms for the flags
  logic [7:0] core_evt_vec;
  always_comb begin
    core_evt_vec = 8'h00;
    core_evt_vec[`CIC_CORE_TMR] = timer_evt;
    core_evt_vec[`CIC_CORE_IOC] = ioc_evt;
    core_evt_vec[`CIC_CORE_EXT] = ext_edge; // R17 R15
  end

  // gating of pending requests
  wire peripheral_group_irq_enable = irq_control_reg[`CIC_CTRL_PERIPHERAL_GROUP_IRQ_ENABLE];
  wire core_pend = |(core_source_flag_reg & core_source_enable_reg); // R03
  wire peri_pend = peripheral_group_irq_enable & (|(peripheral_flag_reg_first & peri_en_reg)); // R02
  wire any_pend = core_pend | peri_pend;
  // only sources that run without the system clock may wake
  wire wake_pend = core_source_flag_reg[`CIC_CORE_EXT] &
    core_source_enable_reg[`CIC_CORE_EXT] |
    peripheral_group_irq_enable & (|(peripheral_flag_reg_first & peri_en_reg & peri_clockless)); // R12
  wire sleeping = (state_reg == cic_pkg::CIC_SLEEP);
  wire wake_now = sleeping & wake_pend; // R12
  // no vectoring while asleep or on the instruction after sleep
  wire take = first_clock_phase & global_irq_enable & any_pend &
    (state_reg == cic_pkg::CIC_RUN) & ~return_from_irq_instr; // R11 R07 R09 R14

  // sleep and wake sequencing
  always_comb begin
    case (state_reg)
      cic_pkg::CIC_RUN:
        state_next = sleep_active ? cic_pkg::CIC_SLEEP : cic_pkg::CIC_RUN;
      cic_pkg::CIC_SLEEP:
        state_next = wake_now ? cic_pkg::CIC_POST_WAKE : cic_pkg::CIC_SLEEP;
      cic_pkg::CIC_POST_WAKE: begin
        // one sampling phase passes so the next instruction executes
        state_next = first_clock_phase ? cic_pkg::CIC_RUN
                                       : cic_pkg::CIC_POST_WAKE; // R14 R13
      end
      default: state_next = cic_pkg::CIC_RUN;
    endcase
  end

  // next values of the software visible registers
  always_comb begin
    irq_control_next = irq_control_reg;
    if (wr_ctrl) begin
      irq_control_next = wd & 8'hc1;
    end
    if (take) begin
      irq_control_next[`CIC_CTRL_GIE] = 1'b0; // R05
    end else if (return_from_irq_instr) begin
      irq_control_next[`CIC_CTRL_GIE] = 1'b1; // R08
    end
    core_source_enable_next = wr_cen ? (wd & `CIC_CORE_MASK)
                                     : core_source_enable_reg;
    peri_en_next = wr_pen ? wd[NPERI-1:0] : peri_en_reg;
    // event set wins over a firmware write of the same flag
    core_source_flag_next = ((wr_cflag ? wd : core_source_flag_reg) |
      core_evt_vec) & `CIC_CORE_MASK; // R04
    peri_flag_next = (wr_pflag ? wd[NPERI-1:0] : peripheral_flag_reg_first)
      | peri_evt; // R04
    irq_stat_next = (irq_stat_reg & ~(wr_stat ? wd[2:0] : 3'h0)) |
      {wake_now, return_from_irq_instr, take};
    irq_mask_next = wr_mask ? wd[2:0] : irq_mask_reg;
  end

  // register file and control state; reset disables vectoring
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_control_reg <= `CIC_CTRL_RST; // R01
      core_source_enable_reg <= 8'h00; // R01
      core_source_flag_reg <= 8'h00;
      peri_en_reg <= '0;
      peripheral_flag_reg_first <= '0;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      state_reg <= cic_pkg::CIC_RUN;
    end else begin
      irq_control_reg <= irq_control_next;
      core_source_enable_reg <= core_source_enable_next;
      core_source_flag_reg <= core_source_flag_next;
      peri_en_reg <= peri_en_next;
      peripheral_flag_reg_first <= peri_flag_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      state_reg <= state_next;
    end
  end

  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= ext_pin; // R18
      pin_s2_reg <= pin_s1_reg; // R18
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // entry, return and wake strobes to the sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vector_take <= 1'b0;
      restore_take <= 1'b0;
      wake <= 1'b0;
      vector_addr <= 16'h0000;
    end else begin
      vector_take <= take; // R05
      restore_take <= return_from_irq_instr; // R08
      wake <= wake_now; // R13
      vector_addr <= `CIC_VECTOR; // R05
    end
  end

  // context shadow, captured on entry; status keeps no timeout/pd
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shd_w <= 8'h00;
      shd_status <= 8'h00;
      shd_bsr <= 6'h00;
      shd_fsr0 <= 16'h0000;
      shd_fsr1 <= 16'h0000;
      shd_pch <= 7'h00;
    end else if (take) begin
      shd_w <= ctx_w; // R06
      shd_status <= ctx_status & ST_SAVE; // R06
      shd_bsr <= ctx_bsr;
      shd_fsr0 <= ctx_fsr0;
      shd_fsr1 <= ctx_fsr1;
      shd_pch <= ctx_pch;
    end
  end

  assign global_irq_enable = irq_control_reg[`CIC_CTRL_GIE];
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // axi write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid & ~aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & ~w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  logic [7:0] rd_val;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (ra)
      `CIC_OFF_CTRL: rd_val = irq_control_reg;
      `CIC_OFF_CORE_EN: rd_val = core_source_enable_reg;
      `CIC_OFF_CORE_FLAG: rd_val = core_source_flag_reg;
      `CIC_OFF_PERI_EN: rd_val = 8'(peri_en_reg);
      `CIC_OFF_PERI_FLAG: rd_val = 8'(peripheral_flag_reg_first);
      `CIC_OFF_SHADOW_ST: rd_val = shd_status;
      `CIC_OFF_IRQ_STAT: rd_val = {5'h00, irq_stat_reg};
      `CIC_OFF_IRQ_MASK: rd_val = {5'h00, irq_mask_reg};
      default: begin
        rd_val = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  // axi read channel, one outstanding read
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_known ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : cic_core

// ---- verilog/cic_map.svh ----
// register offsets, field positions, reset values and constants for cic
`ifndef CIC_MAP_SVH
`define CIC_MAP_SVH
`define CIC_OFF_CTRL 8'h00
`define CIC_OFF_CORE_EN 8'h04
`define CIC_OFF_CORE_FLAG 8'h08
`define CIC_OFF_PERI_EN 8'h0c
`define CIC_OFF_PERI_FLAG 8'h10
`define CIC_OFF_SHADOW_ST 8'h14
`define CIC_OFF_IRQ_STAT 8'h18
`define CIC_OFF_IRQ_MASK 8'h1c
`define CIC_CTRL_GIE 7
`define CIC_CTRL_PERIPHERAL_GROUP_IRQ_ENABLE 6
`define CIC_CTRL_EDGE 0
`define CIC_CTRL_RST 8'h01
`define CIC_CORE_TMR 5
`define CIC_CORE_IOC 4
`define CIC_CORE_EXT 0
`define CIC_CORE_MASK 8'h31
`define CIC_ST_TO 4
`define CIC_ST_PD 3
`define CIC_EV_ENTRY 0
`define CIC_EV_RETURN 1
`define CIC_EV_WAKE 2
`define CIC_VECTOR 16'h0004
`endif

// ---- verilog/cic_pkg.sv ----
// types shared by the interrupt control block
package cic_pkg;
  typedef enum logic [2:0] {
    CIC_RUN = 3'b001,
    CIC_SLEEP = 3'b010,
    CIC_POST_WAKE = 3'b100
  } cic_state_t;
endpackage : cic_pkg
